/* File: include/ptc_defs.vh */
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH

`define PTC_ADR_W        8
`define PTC_CNT_W        10
`define PTC_CNT_MAX      10'h3FF
`define PTC_CNT_ZERO     10'h000
`define PTC_CNT_ONE      10'h001

`define PTC_ADR_CTRL0    8'h00
`define PTC_ADR_CTRL1    8'h04
`define PTC_ADR_CTRL2    8'h08
`define PTC_ADR_COUNT    8'h0C
`define PTC_ADR_CMPA     8'h10
`define PTC_ADR_CMPB     8'h14
`define PTC_ADR_PERIOD   8'h18
`define PTC_ADR_STEP     8'h04

`define PTC_EN_BIT       3
`define PTC_MODE_HI      7
`define PTC_MODE_LO      6
`define PTC_ACT_HI       5
`define PTC_ACT_LO       4
`define PTC_INIT_BIT     3
`define PTC_INV_BIT      2
`define PTC_CSRC_BIT     1
`define PTC_CLR_BIT      0
`define PTC_TCLR_HI      2
`define PTC_TCLR_LO      1
`define PTC_VLF_BIT      0

`define PTC_CTRL1_RST    8'h00
`define PTC_TCLR_RST     2'h0

`define PTC_MODE_CMP     2'h0
`define PTC_MODE_CAP     2'h1
`define PTC_MODE_PWM     2'h2
`define PTC_MODE_TMR     2'h3

`define PTC_ACT_00       2'h0
`define PTC_ACT_01       2'h1
`define PTC_ACT_10       2'h2
`define PTC_ACT_11       2'h3

`define PTC_TCLR_P       2'h0
`define PTC_TCLR_RISE    2'h1
`define PTC_TCLR_FALL    2'h2
`define PTC_TCLR_BOTH    2'h3

`endif

/* File: logic/ptc_edge_detect.v */
`timescale 1ns/1ns
module ptc_edge_detect
(
    input  wire clk,
    input  wire rstn,
    input  wire sig,
    output wire rise,
    output wire fall
);
    reg prev_reg;

    always @(posedge clk)
    begin
        if (!rstn)
            prev_reg <= 1'b0;
        else
            prev_reg <= sig;
    end

    assign rise = sig & ~prev_reg;
    assign fall = ~sig & prev_reg;
endmodule // ptc_edge_detect

/* File: logic/ptc_match.v */
`timescale 1ns/1ns
`include "ptc_defs.vh"
module ptc_match
(
    input  wire [`PTC_CNT_W-1:0] count,
    input  wire [`PTC_CNT_W-1:0] cmpA,
    input  wire [`PTC_CNT_W-1:0] period,
    output wire                  matchA,
    output wire                  matchP,
    output wire                  belowA
);
    assign matchA = (count == cmpA);
    // A zero period means the counter runs its full range and wraps.
    assign matchP = (period != `PTC_CNT_ZERO) && (count == period); // [RULE15]
    assign belowA = (count < cmpA);
endmodule // ptc_match

/* File: logic/ptc_timer_ctrl.v */
`timescale 1ns/1ns
`include "ptc_defs.vh"
// Operation
// [RULE1] Compare mode, A match: 00 hold, 01 low, 10 high, 11 toggle.
// [RULE2] PWM mode: 00 inactive, 01 active, 10 PWM waveform, 11 single pulse.
// [RULE3] Capture, clear cond 00: rise, fall or both into A; 11 none.
// [RULE4] Capture, clear cond nonzero: rise->B, fall->A, both split, 11 none.
// [RULE5] Capture source bit 0 uses capture pin, 1 uses external clock pin.
// [RULE6] Timer/counter mode ignores action, initial level and invert; pin undriven.
// [RULE7] Compare mode output starts at the initial-level bit.
// [RULE8] PWM mode initial-level bit selects active high or active low.
// [RULE9] Single pulse mode applies initial level when enable rises.
// [RULE10] Requested level equal to current level gives no visible change.
// [RULE11] Enable rising returns the compare output to its initial level.
// [RULE12] Invert bit 1 inverts the output at the pin.
// [RULE13] Software changes the action field only while the timer is off.
// [RULE14] Clear-select 1 clears on A match; 0 on P match or overflow.
// [RULE15] Overflow clearing only when period value is zero.
// [RULE16] Clear-select is ignored in PWM, single pulse and capture modes.
// [RULE17] Without the capture pin, software keeps capture source at 1.
// [RULE18] Mode 00 compare, 01 capture, 10 PWM or pulse, 11 timer.
// [RULE19] Enable rising zeroes the counter; enable falling holds the count.
// [RULE20] Capture clear cond: P match plus rise, fall or both edges.
module ptc_timer_ctrl
(
    input  wire                  clk,
    input  wire                  rstn,
    input  wire                  wb_cyc_i,
    input  wire                  wb_stb_i,
    input  wire                  wb_we_i,
    input  wire [`PTC_ADR_W-1:0] wb_adr_i,
    input  wire [3:0]            wb_sel_i,
    input  wire [31:0]           wb_dat_i,
    output reg  [31:0]           wb_dat_o,
    output reg                   wb_ack_o,
    input  wire                  captureInputPin,
    input  wire                  externalClockPin,
    output reg                   timerOutputPin,
    output reg                   timerOutputEn
);
    reg                   enable_reg;
    reg                   enPrev_reg;
    reg [7:0]             ctrl1_reg;
    reg [1:0]             tclr_reg;
    reg                   vlf_reg;
    reg [`PTC_CNT_W-1:0]  cnt_reg;
    reg [`PTC_CNT_W-1:0]  cmp_reg [0:2];
    reg                   outLevel_reg;
    reg                   outLevel_next;
    reg                   pulseDone_reg;
    reg                   cntClear;
    reg [31:0]            readData;

    wire [1:0] mode      = ctrl1_reg[`PTC_MODE_HI:`PTC_MODE_LO];
    wire [1:0] action    = ctrl1_reg[`PTC_ACT_HI:`PTC_ACT_LO];
    wire       initLevel = ctrl1_reg[`PTC_INIT_BIT];
    wire       invert    = ctrl1_reg[`PTC_INV_BIT];
    wire       capSrc    = ctrl1_reg[`PTC_CSRC_BIT];
    wire       clrSel    = ctrl1_reg[`PTC_CLR_BIT];
    wire       enRise    = enable_reg & ~enPrev_reg;

    wire busReq = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where the master sees ack, never earlier.
    wire wrLo   = busReq & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire wrHi   = busReq & wb_we_i & wb_ack_o & wb_sel_i[1];

    // The edge detector follows the selected pin, so switching source while running can look like an edge.
    wire capSig = capSrc ? externalClockPin : captureInputPin; // [RULE5]
    wire capRise;
    wire capFall;
    wire matchA;
    wire matchP;
    wire belowA;
    wire [1:0] capLoad;
    wire       capEvent;

    function isOutMode;
        input [1:0] m;
        begin
            isOutMode = (m == `PTC_MODE_CMP) || (m == `PTC_MODE_PWM); // [RULE18]
        end
    endfunction

    // One decode serves every register write strobe.
    function wrHit;
        input                  strobe;
        input [`PTC_ADR_W-1:0] adr;
        input [`PTC_ADR_W-1:0] target;
        begin
            wrHit = strobe && (adr == target);
        end
    endfunction

    // Returns {load B, load A} for one capture edge pair.
    function [1:0] capDecode;
        input [1:0] act;
        input       tclrZero;
        input       rise;
        input       fall;
        begin
            capDecode = 2'h0;
            if (tclrZero)
            begin
                case (act) // [RULE3]
                    `PTC_ACT_00: capDecode = {1'b0, rise};
                    `PTC_ACT_01: capDecode = {1'b0, fall};
                    `PTC_ACT_10: capDecode = {1'b0, rise | fall};
                    default:     capDecode = 2'h0;
                endcase
            end
            else
            begin
                case (act) // [RULE4]
                    `PTC_ACT_00: capDecode = {rise, 1'b0};
                    `PTC_ACT_01: capDecode = {1'b0, fall};
                    `PTC_ACT_10: capDecode = {rise, fall};
                    default:     capDecode = 2'h0;
                endcase
            end
        end
    endfunction

    ptc_edge_detect capEdge
    (
        .clk  (clk),
        .rstn (rstn),
        .sig  (capSig),
        .rise (capRise),
        .fall (capFall)
    );

    ptc_match cmpUnit
    (
        .count  (cnt_reg),
        .cmpA   (cmp_reg[0]),
        .period (cmp_reg[2]),
        .matchA (matchA),
        .matchP (matchP),
        .belowA (belowA)
    );

    // Captures happen only while the counter runs in capture mode.
    assign capLoad  = (enable_reg && mode == `PTC_MODE_CAP) ?
                      capDecode(action, tclr_reg == `PTC_TCLR_P, capRise, capFall) : 2'h0;
    assign capEvent = capLoad[0] | capLoad[1];

    always @*
    begin
        cntClear = 1'b0;
        case (mode) // [RULE18]
            `PTC_MODE_CMP, `PTC_MODE_TMR:
                cntClear = clrSel ? matchA : matchP; // [RULE14]
            `PTC_MODE_PWM:
                cntClear = matchP; // [RULE16]
            default:
            begin
                cntClear = matchP; // [RULE16]
                case (tclr_reg) // [RULE20]
                    `PTC_TCLR_RISE: cntClear = matchP | capRise;
                    `PTC_TCLR_FALL: cntClear = matchP | capFall;
                    `PTC_TCLR_BOTH: cntClear = matchP | capRise | capFall;
                    default:        cntClear = matchP;
                endcase
            end
        endcase
    end

    // A zero period lets the counter wrap from its maximum back to zero.
    always @(posedge clk)
    begin
        if (!rstn)
            cnt_reg <= `PTC_CNT_ZERO;
        else if (enRise)
            cnt_reg <= `PTC_CNT_ZERO; // [RULE19]
        else if (enable_reg)
            cnt_reg <= cntClear ? `PTC_CNT_ZERO : cnt_reg + `PTC_CNT_ONE; // [RULE14] [RULE15]
    end

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            enable_reg <= 1'b0;
            enPrev_reg <= 1'b0;
            ctrl1_reg  <= `PTC_CTRL1_RST;
            tclr_reg   <= `PTC_TCLR_RST;
        end
        else
        begin
            enPrev_reg <= enable_reg;
            if (wrHit(wrLo, wb_adr_i, `PTC_ADR_CTRL0))
                enable_reg <= wb_dat_i[`PTC_EN_BIT]; // [RULE19]
            // The action field is not guarded; changing it while running is unsafe.
            if (wrHit(wrLo, wb_adr_i, `PTC_ADR_CTRL1))
                ctrl1_reg <= wb_dat_i[7:0]; // [RULE13]
            if (wrHit(wrLo, wb_adr_i, `PTC_ADR_CTRL2))
                tclr_reg <= wb_dat_i[`PTC_TCLR_HI:`PTC_TCLR_LO];
        end
    end

    // Compare A, compare B and period share one write path; capture beats software.
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1)
        begin : cmpRegs
            localparam integer          ADR_INT = `PTC_ADR_CMPA + i * `PTC_ADR_STEP;
            localparam [`PTC_ADR_W-1:0] ADR     = ADR_INT[`PTC_ADR_W-1:0];
            wire cap;
            // Only A and B take captures; the period register is written by software alone.
            if (i < 2)
            begin : withCap
                assign cap = capLoad[i];
            end
            else
            begin : noCap
                assign cap = 1'b0;
            end
            always @(posedge clk)
            begin
                if (!rstn)
                    cmp_reg[i] <= `PTC_CNT_ZERO;
                else if (cap)
                    cmp_reg[i] <= cnt_reg; // [RULE3] [RULE4]
                else
                begin
                    if (wrHit(wrLo, wb_adr_i, ADR))
                        cmp_reg[i][7:0] <= wb_dat_i[7:0];
                    if (wrHit(wrHi, wb_adr_i, ADR))
                        cmp_reg[i][`PTC_CNT_W-1:8] <= wb_dat_i[`PTC_CNT_W-1:8];
                end
            end
        end
    endgenerate

    // Latch edge flag: 1 after a rising-edge capture, 0 after a falling one.
    always @(posedge clk)
    begin
        if (!rstn)
            vlf_reg <= 1'b0;
        else if (capEvent)
        begin
            if (capLoad[1])
                vlf_reg <= 1'b1;
            else
                vlf_reg <= capRise;
        end
    end

    // The pulse ends at the first A match and stays ended until the next enable rise.

    always @(posedge clk)
    begin
        if (!rstn)
            pulseDone_reg <= 1'b0;
        else if (enRise)
            pulseDone_reg <= 1'b0;
        else if (enable_reg && mode == `PTC_MODE_PWM && action == `PTC_ACT_11 && matchA)
            pulseDone_reg <= 1'b1;
    end

    always @*
    begin
        outLevel_next = outLevel_reg;
        if (enRise && isOutMode(mode))
            outLevel_next = initLevel; // [RULE7] [RULE9] [RULE11]
        else if (enable_reg && mode == `PTC_MODE_CMP && matchA)
        begin
            // Driving the level already present shows no change at the pin.
            case (action) // [RULE1] [RULE10]
                `PTC_ACT_01: outLevel_next = 1'b0;
                `PTC_ACT_10: outLevel_next = 1'b1;
                `PTC_ACT_11: outLevel_next = ~outLevel_reg;
                default:     outLevel_next = outLevel_reg;
            endcase
        end
        else if (enable_reg && mode == `PTC_MODE_PWM)
        begin
            case (action) // [RULE2] [RULE8]
                `PTC_ACT_00: outLevel_next = ~initLevel;
                `PTC_ACT_01: outLevel_next = initLevel;
                `PTC_ACT_10: outLevel_next = belowA ? initLevel : ~initLevel;
                default:     outLevel_next = (pulseDone_reg | matchA) ? ~initLevel : initLevel;
            endcase
        end
    end

    // The pin is released in capture and timer modes so that it can serve another function.
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            outLevel_reg   <= 1'b0;
            timerOutputPin <= 1'b0;
            timerOutputEn  <= 1'b0;
        end
        else
        begin
            outLevel_reg <= outLevel_next;
            if (isOutMode(mode))
            begin
                timerOutputPin <= outLevel_next ^ invert; // [RULE12]
                timerOutputEn  <= 1'b1;
            end
            else
            begin
                timerOutputPin <= 1'b0; // [RULE6]
                timerOutputEn  <= 1'b0;
            end
        end
    end

    always @*
    begin
        readData = 32'h00000000;
        if (wb_adr_i == `PTC_ADR_CTRL0)
            readData[`PTC_EN_BIT] = enable_reg;
        else if (wb_adr_i == `PTC_ADR_CTRL1)
            readData[7:0] = ctrl1_reg;
        else if (wb_adr_i == `PTC_ADR_CTRL2)
            readData[`PTC_TCLR_HI:`PTC_VLF_BIT] = {tclr_reg, vlf_reg};
        else if (wb_adr_i == `PTC_ADR_COUNT)
            readData[`PTC_CNT_W-1:0] = cnt_reg;
        else if (wb_adr_i == `PTC_ADR_CMPA)
            readData[`PTC_CNT_W-1:0] = cmp_reg[0];
        else if (wb_adr_i == `PTC_ADR_CMPB)
            readData[`PTC_CNT_W-1:0] = cmp_reg[1];
        else if (wb_adr_i == `PTC_ADR_PERIOD)
            readData[`PTC_CNT_W-1:0] = cmp_reg[2];
    end

    // One wait state; unmapped addresses still answer, reading zero.
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= busReq & ~wb_ack_o;
            if (busReq && !wb_ack_o)
                wb_dat_o <= readData;
        end
    end
endmodule // ptc_timer_ctrl

/* File: verif/ptc_timer_monitor.sv */
`timescale 1ns/1ns
`include "ptc_defs.vh"
module ptc_timer_monitor (
    input wire        clk,
    input wire        rstn,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        captureInputPin,
    input wire        externalClockPin,
    input wire        timerOutputPin,
    input wire        timerOutputEn
);
    logic [7:0] ctrlOneReg;
    logic [3:0] ageReg;
    wire        rdAck = wb_ack_o && !wb_we_i;
    wire        wrOne = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `PTC_ADR_CTRL1;
    // A shadow of the control byte lets mode checks run without probing the design's insides.
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            ctrlOneReg <= 8'h00;
            ageReg     <= 4'h0;
        end
        else
        begin
            if (wrOne)
                ctrlOneReg <= wb_dat_i[7:0];
            ageReg <= wrOne ? 4'h0 : (ageReg == 4'hF ? ageReg : ageReg + 4'h1);
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    pin_enable_a: assert property (ageReg > 4'h2 |-> timerOutputEn == !ctrlOneReg[6])
        else $error("pin enable does not follow mode");
    timer_pin_a: assert property (ageReg > 4'h2 && ctrlOneReg[7:6] == 2'h3 |-> !timerOutputPin)
        else $error("pin active in timer mode");
    ctrl_read_a: assert property (rdAck && wb_adr_i == `PTC_ADR_CTRL1 |-> wb_dat_o[7:0] == ctrlOneReg)
        else $error("control byte read back wrong");
    unmapped_read_a: assert property (rdAck && wb_adr_i > `PTC_ADR_PERIOD |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    value_read_a: assert property (rdAck && wb_adr_i >= `PTC_ADR_COUNT |-> wb_dat_o[31:10] == 22'h0)
        else $error("count field too wide");
endmodule // ptc_timer_monitor
bind ptc_timer_ctrl ptc_timer_monitor u_ptc_timer_monitor (.*);

/* File: verif/ptc_pin_model.sv */
`timescale 1ns/1ns
module ptc_pin_model (
    input  wire  clk,
    input  wire  capLvl,
    input  wire  extLvl,
    output logic capPin = 1'b0,
    output logic extPin = 1'b0
);
    // Pins move only just after an edge, like a synchronous external source.
    always @(posedge clk)
    begin
        capPin <= capLvl;
        extPin <= extLvl;
    end
endmodule // ptc_pin_model

/* File: verif/test_periodic_timer_output_capture_ctrl.sv */
`timescale 1ns/1ns
`include "ptc_defs.vh"
module test_periodic_timer_output_capture_ctrl;
    logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        capLvl = 1'b0, extLvl = 1'b0, src = 1'b0, ea, eb;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, r, r2;
    wire  [31:0] rdat;
    wire         ack, cpin, epin, opin, oen;
    int          mismatches = 0, comparisons = 0;
    always #10 clk = ~clk;
    ptc_pin_model u_ptc_pin_model (.clk(clk), .capLvl(capLvl), .extLvl(extLvl), .capPin(cpin), .extPin(epin));
    ptc_timer_ctrl u_ptc_timer_ctrl (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .captureInputPin(cpin), .externalClockPin(epin), .timerOutputPin(opin), .timerOutputEn(oen));
    task w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task xf(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        sel <= 4'h3;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task ck(input logic ok);
        comparisons++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("mismatch at %0t: unexpected value", $time);
        end
    endtask
    task pn(input logic u, input logic s, input int n);
        capLvl <= src ? u : s;
        extLvl <= src ? s : u;
        w(n);
    endtask
    task t_regs;
        xf(0, `PTC_ADR_CTRL1, 0);
        ck(r === 32'h0);
        xf(1, `PTC_ADR_CTRL1, 32'hA5);
        xf(0, `PTC_ADR_CTRL1, 0);
        ck(r === 32'hA5);
        xf(1, `PTC_ADR_CMPA, 32'h3FF);
        xf(0, `PTC_ADR_CMPA, 0);
        ck(r === 32'h3FF);
        xf(1, 8'h1C, 32'hFF);
        xf(0, 8'h1C, 0);
        ck(r === 32'h0);
        xf(1, `PTC_ADR_COUNT, 32'h55);
        xf(0, `PTC_ADR_COUNT, 0);
        ck(r === 32'h0);
    endtask
    task t_cmp;
        xf(1, `PTC_ADR_CMPA, 32'h3);
        xf(1, `PTC_ADR_PERIOD, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            ea = i[1:0] == 0 ? i[2] : (i[1:0] == 3 ? !i[2] : i[1]);
            xf(1, `PTC_ADR_CTRL0, 0);
            xf(1, `PTC_ADR_CTRL1, {26'h0, i[1:0], i[2], i[1] ^ i[2], 2'h0});
            xf(1, `PTC_ADR_CTRL0, 32'h8);
            w(2);
            ck(opin === (i[2] ^ i[1] ^ i[2]));
            ck(oen === 1'b1);
            w(10);
            ck(opin === (ea ^ i[1] ^ i[2]));
        end
    endtask
    task t_pwm;
        xf(1, `PTC_ADR_PERIOD, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            xf(1, `PTC_ADR_CTRL0, 0);
            xf(1, `PTC_ADR_CTRL1, {24'h0, 2'h2, 1'b0, k[0], k[1], k[0], 2'h0});
            xf(1, `PTC_ADR_CTRL0, 32'h8);
            w(3);
            ck(opin === !k[1]);
        end
        xf(1, `PTC_ADR_CTRL0, 0);
        xf(1, `PTC_ADR_CMPA, 32'h5);
        xf(1, `PTC_ADR_CTRL1, 32'hB9);
        xf(1, `PTC_ADR_CTRL0, 32'h8);
        w(2);
        ck(opin === 1'b1);
        w(20);
        ck(opin === 1'b0);
        xf(0, `PTC_ADR_COUNT, 0);
        ck(r > 32'h5);
        xf(1, `PTC_ADR_CTRL0, 0);
        xf(1, `PTC_ADR_PERIOD, 32'h8);
        xf(1, `PTC_ADR_CTRL1, 32'hA8);
        xf(1, `PTC_ADR_CTRL0, 32'h8);
        w(4);
        ck(opin === 1'b1);
        w(5);
        ck(opin === 1'b0);
        w(4);
        ck(opin === 1'b1);
        xf(1, `PTC_ADR_PERIOD, 32'h0);
    endtask
    task t_clr;
        xf(1, `PTC_ADR_CTRL0, 0);
        xf(1, `PTC_ADR_CTRL1, 0);
        xf(1, `PTC_ADR_CTRL0, 32'h8);
        w(30);
        xf(0, `PTC_ADR_COUNT, 0);
        ck(r > 32'h14);
        xf(1, `PTC_ADR_CTRL0, 0);
        xf(0, `PTC_ADR_COUNT, 0);
        r2 = r;
        w(5);
        xf(0, `PTC_ADR_COUNT, 0);
        ck(r === r2);
        xf(1, `PTC_ADR_CTRL0, 32'h8);
        xf(0, `PTC_ADR_COUNT, 0);
        ck(r < 32'h4);
        xf(1, `PTC_ADR_CTRL0, 0);
        xf(1, `PTC_ADR_CTRL1, 32'h1);
        xf(1, `PTC_ADR_CTRL0, 32'h8);
        w(30);
        xf(0, `PTC_ADR_COUNT, 0);
        ck(r <= 32'h5);
        xf(1, `PTC_ADR_CTRL0, 0);
        xf(1, `PTC_ADR_CTRL1, 0);
        xf(1, `PTC_ADR_PERIOD, 32'h8);
        xf(1, `PTC_ADR_CTRL0, 32'h8);
        w(30);
        xf(0, `PTC_ADR_COUNT, 0);
        ck(r <= 32'h8);
    endtask
    task t_cap;
        for (int i = 0; i < 32; i++)
        begin
            src = i[1];
            xf(1, `PTC_ADR_CTRL0, 0);
            xf(1, `PTC_ADR_CMPA, 0);
            xf(1, `PTC_ADR_CMPB, 0);
            xf(1, `PTC_ADR_CTRL2, {29'h0, 1'b0, i[4], 1'b0});
            xf(1, `PTC_ADR_CTRL1, {24'h0, 2'h1, i[3:2], 2'h0, i[1], 1'b0});
            pn(1'b0, i[0], 1);
            xf(1, `PTC_ADR_CTRL0, 32'h8);
            w(4);
            pn(1'b1, i[0], 3);
            pn(1'b0, i[0], 3);
            pn(1'b0, !i[0], 4);
            ck(oen === 1'b0);
            xf(0, `PTC_ADR_CMPA, 0);
            r2 = r;
            xf(0, `PTC_ADR_CMPB, 0);
            ea = (i[3:2] == 2 && (!i[4] || i[0])) || (i[3:2] == 1 && i[0]) || (!i[4] && i[3:2] == 0 && !i[0]);
            eb = i[4] && !i[0] && !i[2] && i[3:2] != 3;
            ck((r2 != 0) === ea);
            ck((r != 0) === eb);
            xf(0, `PTC_ADR_CTRL2, 0);
            if (ea || eb)
                ck(r[0] === !i[0]);
        end
    endtask
    task t_tmr;
        xf(1, `PTC_ADR_CTRL0, 0);
        xf(1, `PTC_ADR_CTRL1, 32'hFC);
        xf(1, `PTC_ADR_CTRL0, 32'h8);
        w(3);
        ck(oen === 1'b0);
        ck(opin === 1'b0);
    endtask
    task final_report;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_cmp;
        t_pwm;
        t_clr;
        t_cap;
        t_tmr;
        final_report;
    end
    initial
    begin
        #600000;
        mismatches++;
        final_report;
    end
endmodule // test_periodic_timer_output_capture_ctrl
